/* File: inc/wakeup_corr_pkg.sv */
// constants, state types and register map of the wakeup correlator
// assumes a 250 MHz aclk and a 32.768 kHz real-time tick derived from it
package wakeup_corr_pkg;
    localparam int          ADDR_W         = 5;
    localparam int          CLK_HZ         = 250_000_000;
    localparam int          RTC_HZ         = 32_768;
    localparam int          RTC_DIV_CYC    = CLK_HZ / RTC_HZ;
    localparam int          TO_STEP_MS     = 50;
    localparam int          TO_STEP_TICKS  = TO_STEP_MS * RTC_HZ / 1000;
    localparam logic [4:0]  OFS_CTRL       = 5'h00;
    localparam logic [4:0]  OFS_TIMING     = 5'h04;
    localparam logic [4:0]  OFS_PAT_HI     = 5'h08;
    localparam logic [4:0]  OFS_PAT_LO     = 5'h0C;
    localparam logic [4:0]  OFS_FALSE      = 5'h10;
    localparam logic [4:0]  OFS_CMD        = 5'h14;
    localparam int          CORR_EN_BIT    = 1;
    localparam int          DOUBLE_BIT     = 2;
    localparam int          DEC_EN_BIT     = 3;
    localparam int          TOL_LSB        = 5;
    localparam int          BP_LSB         = 0;
    localparam int          TO_LSB         = 5;
    localparam int          CLEAR_WAKE_BIT = 0;
    localparam logic [7:0]  CTRL_MASK      = 8'h6E;
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [7:0]  TIMING_RST     = 8'h0F;
    localparam logic [7:0]  PAT_HI_RST     = 8'h96;
    localparam logic [7:0]  PAT_LO_RST     = 8'h69;
    localparam logic [4:0]  BP_MIN_CODE    = 5'h03;
    localparam logic [5:0]  CARRIER_WAIT   = 6'h10;
    localparam logic [2:0]  PREAMBLE_MIN   = 3'h4;
    localparam logic [5:0]  FRAME_MAX      = 6'h28;
    localparam logic [5:0]  PATTERN_CHIPS  = 6'h10;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [2:0] {
        ST_LISTEN, ST_PREAMBLE, ST_PATTERN, ST_DOUBLE, ST_WAKE
    } corr_state_t;

    typedef struct packed {
        logic [1:0]        car_sync;
        logic [1:0]        dat_sync;
        logic              car_prev;
        logic [7:0]        ctrl;
        logic [7:0]        timing;
        logic [7:0]        pat_hi;
        logic [7:0]        pat_lo;
        logic [7:0]        fcnt;
        logic              aw_held;
        logic              w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0]        wdata;
        logic              wlane;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic [12:0]       rtc_cnt;
        logic [4:0]        tick_cnt;
        logic [5:0]        chip_cnt;
        logic [2:0]        pre_cnt;
        logic              last_chip;
        logic [15:0]       shift;
        corr_state_t       st;
        logic [13:0]       to_cnt;
        logic              dec_phase;
        logic              dec_first;
        logic              dec_data;
        logic              dec_clk;
        logic              wake;
    } corr_core_t;
endpackage

/* File: hdl/wakeup_pattern_correlator.sv */
// wakeup correlator: preamble and pattern check, manchester decode, timeout
// assumes carrier_detect and demod_data come asynchronously from the slicer
//
// Function
// R1: correlation after carrier detect runs only when correlator_enable is one
// R2: no preamble within 16 bit periods: back to listening, count false wakeup
// R3: pattern search starts after at least four alternating preamble bits
// R4: bit period is bit_period_select plus one rtc periods, 4 to 32
// R5: transmitter keeps preamble plus pattern within 40 bit periods
// R6: pattern is two written bytes, sixteen half-bit chips, manchester coded
// R7: low-to-high within a bit is zero, high-to-low is one
// R8: pattern resets to hex 96 and is compared msb first; the code resets it to hex 9669
// R9: transmitter sends the pattern msb first
// R10: double_pattern_select demands the pattern twice in succession
// R11: missed_zero_tolerance allows zero to three missed zero chips
// R12: a pattern match raises the wake output
// R13: decoder enabled: decoded data and recovered clock drive their pins
// R14: decoded data is stable at the recovered clock rising edge
// R15: failed detection ends internal wakeup silently, counts false wakeup
// R16: clear-wake command ends the wake state, back to listening
// R17: auto_timeout_select ends wake after code times 50 ms, 0 disables
// R18: timeout count starts at the rising edge of wake
// R19: correlator disabled: wake on carrier detection alone
// R20: bit period codes below 00011 are reserved and act as 00011
// R21: false wakeup counter saturates at its maximum
`timescale 1ns/1ps
`default_nettype none
module wakeup_pattern_correlator
    import wakeup_corr_pkg::*;
#(
    parameter int RTC_DIV = RTC_DIV_CYC,   // aclk cycles per rtc period
    parameter int TO_STEP = TO_STEP_TICKS  // rtc periods per timeout step
)(
    input  wire logic              aclk,          // 250 MHz clock
    input  wire logic              aresetn,       // sync reset, active low
    input  wire logic [ADDR_W-1:0] awaddr,        // write address
    input  wire logic              awvalid,       // write address valid
    output logic                   awready,       // write address ready
    input  wire logic [31:0]       wdata,         // write data
    input  wire logic [3:0]        wstrb,         // write byte enables
    input  wire logic              wvalid,        // write data valid
    output logic                   wready,        // write data ready
    output logic [1:0]             bresp,         // write response
    output logic                   bvalid,        // write response valid
    input  wire logic              bready,        // write response ready
    input  wire logic [ADDR_W-1:0] araddr,        // read address
    input  wire logic              arvalid,       // read address valid
    output logic                   arready,       // read address ready
    output logic [31:0]            rdata,         // read data
    output logic [1:0]             rresp,         // read response
    output logic                   rvalid,        // read data valid
    input  wire logic              rready,        // read data ready
    input  wire logic              carrier_detect, // async carrier present
    input  wire logic              demod_data,    // async demodulated chips
    output logic                   wake,          // wake interrupt to host
    output logic                   decoded_bitstream_out, // decoded data
    output logic                   recovered_bit_clock    // recovered clock
);
    corr_core_t s;
    corr_core_t n;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == OFS_CTRL || a == OFS_TIMING || a == OFS_PAT_HI ||
               a == OFS_PAT_LO || a == OFS_FALSE || a == OFS_CMD;
    endfunction

    // only missed zeros are forgiven; a missing one always fails
    function automatic logic pattern_ok(input logic [15:0] rx,
                                        input logic [15:0] pat,
                                        input logic [1:0]  tol);
        logic [4:0] miss;
        miss = 5'h00;
        for (int i = 0; i < 16; i++)
            miss = miss + {4'h0, ~pat[i] & rx[i]};
        return !(|(pat & ~rx)) && (miss <= {3'h0, tol});
    endfunction

    logic        car_rise;
    logic        chip;
    logic        rtc_tick;
    logic        push;
    logic        fail;
    logic        clear_cmd;
    logic        do_write;
    logic [4:0]  eff_code;
    logic [15:0] pattern;
    logic [15:0] shifted;
    logic [13:0] to_limit;
    logic [2:0]  to_code;

    always_comb
    begin
        n         = s;
        fail      = 1'b0;
        car_rise  = s.car_sync[1] & ~s.car_prev;
        chip      = s.dat_sync[1];
        pattern   = {s.pat_hi, s.pat_lo};                          // R6 R8
        shifted   = {s.shift[14:0], chip};                         // R8
        eff_code  = s.timing[BP_LSB +: 5];
        if (eff_code < BP_MIN_CODE)
            eff_code = BP_MIN_CODE;                                // R20
        to_code   = s.timing[TO_LSB +: 3];
        to_limit  = 14'(to_code * TO_STEP);                        // R17
        rtc_tick  = s.rtc_cnt == 13'(RTC_DIV - 1);
        push      = rtc_tick && s.tick_cnt == (eff_code >> 1);
        do_write  = s.aw_held && s.w_held && !s.bvalid;
        clear_cmd = do_write && s.awaddr == OFS_CMD && s.wlane &&
                    s.wdata[CLEAR_WAKE_BIT];
        n.car_sync = {s.car_sync[0], carrier_detect};
        n.dat_sync = {s.dat_sync[0], demod_data};
        n.car_prev = s.car_sync[1];
        n.rtc_cnt  = rtc_tick ? 13'h0000 : s.rtc_cnt + 13'h0001;
        // register bus
        if (awvalid && awready)
        begin
            n.aw_held = 1'b1;
            n.awaddr  = awaddr;
        end
        if (wvalid && wready)
        begin
            n.w_held = 1'b1;
            n.wdata  = wdata[7:0];
            n.wlane  = wstrb[0];
        end
        if (do_write)
        begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (s.wlane)
            begin
                case (s.awaddr)
                    OFS_CTRL:   n.ctrl   = s.wdata & CTRL_MASK;
                    OFS_TIMING: n.timing = s.wdata;
                    OFS_PAT_HI: n.pat_hi = s.wdata;
                    OFS_PAT_LO: n.pat_lo = s.wdata;
                    default:    n.ctrl   = n.ctrl;
                endcase
            end
        end
        if (s.bvalid && bready)
            n.bvalid = 1'b0;
        if (s.rvalid && rready)
            n.rvalid = 1'b0;
        if (arvalid && arready)
        begin
            n.rvalid = 1'b1;
            n.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
                OFS_CTRL:   n.rdata = {24'h000000, s.ctrl};
                OFS_TIMING: n.rdata = {24'h000000, s.timing};
                OFS_PAT_HI: n.rdata = {24'h000000, s.pat_hi};
                OFS_PAT_LO: n.rdata = {24'h000000, s.pat_lo};
                OFS_FALSE:  n.rdata = {24'h000000, s.fcnt};
                OFS_CMD:    n.rdata = {28'h0000000, s.st, s.wake};
                default:    n.rdata = 32'h00000000;
            endcase
        end

        // chip timing, one sample per bit period mid point
        if (rtc_tick)
            n.tick_cnt = (s.tick_cnt == eff_code) ? 5'h00
                                                  : s.tick_cnt + 5'h01; // R4
        if (push)
        begin
            n.shift     = shifted;
            n.last_chip = chip;
            n.chip_cnt  = s.chip_cnt + 6'h01;
        end
        case (s.st)
            ST_LISTEN:
            begin
                n.tick_cnt = 5'h00;
                n.chip_cnt = 6'h00;
                n.pre_cnt  = 3'h0;
                if (car_rise)
                begin
                    if (!s.ctrl[CORR_EN_BIT])
                    begin
                        n.st   = ST_WAKE;                           // R19
                        n.wake = 1'b1;
                    end
                    else
                        n.st = ST_PREAMBLE;                         // R1
                end
            end
            ST_PREAMBLE:
                if (push)
                begin
                    if (chip != s.last_chip && s.chip_cnt != 6'h00)
                        n.pre_cnt = s.pre_cnt + 3'h1;
                    else
                        n.pre_cnt = 3'h1;
                    if (n.pre_cnt >= PREAMBLE_MIN)
                    begin
                        n.st       = ST_PATTERN;                    // R3
                        n.chip_cnt = {3'h0, PREAMBLE_MIN};
                    end
                    else if (n.chip_cnt >= CARRIER_WAIT)
                        fail = 1'b1;                                // R2
                end
            ST_PATTERN:
                if (push)
                begin
                    if (pattern_ok(shifted, pattern, s.ctrl[TOL_LSB +: 2]) &&
                        n.chip_cnt >= {3'h0, PREAMBLE_MIN} + PATTERN_CHIPS)
                    begin                                           // R11
                        n.chip_cnt = 6'h00;
                        if (s.ctrl[DOUBLE_BIT])
                            n.st = ST_DOUBLE;                       // R10
                        else
                        begin
                            n.st   = ST_WAKE;                       // R12
                            n.wake = 1'b1;
                        end
                    end
                    else if (n.chip_cnt >= FRAME_MAX)
                        fail = 1'b1;                                // R15
                end
            ST_DOUBLE:
                if (push && n.chip_cnt == PATTERN_CHIPS)
                begin
                    if (pattern_ok(shifted, pattern, s.ctrl[TOL_LSB +: 2]))
                    begin
                        n.st   = ST_WAKE;                           // R10
                        n.wake = 1'b1;
                    end
                    else
                        fail = 1'b1;                                // R15
                end
            ST_WAKE:
            begin
                if (rtc_tick && to_code != 3'h0)
                    n.to_cnt = s.to_cnt + 14'h0001;                 // R18
                if (push && s.ctrl[DEC_EN_BIT])
                begin
                    n.dec_phase = ~s.dec_phase;
                    if (!s.dec_phase)
                    begin
                        n.dec_first = chip;
                        n.dec_clk   = 1'b1;                         // R14
                    end
                    else
                    begin
                        n.dec_data = s.dec_first & ~chip;           // R7
                        n.dec_clk  = 1'b0;
                    end
                end
                if (clear_cmd ||
                    (to_code != 3'h0 && n.to_cnt >= to_limit))      // R16 R17
                begin
                    n.st   = ST_LISTEN;
                    n.wake = 1'b0;
                end
            end
            default:
                n.st = ST_LISTEN;
        endcase

        if (fail)
        begin
            n.st = ST_LISTEN;                                       // R15
            if (s.fcnt != 8'hFF)
                n.fcnt = s.fcnt + 8'h01;                            // R21
        end
        if (!n.wake)
        begin
            n.to_cnt    = 14'h0000;                                 // R18
            n.dec_phase = 1'b0;
            n.dec_clk   = 1'b0;
            n.dec_data  = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s        <= '0;
            s.ctrl   <= CTRL_RST;
            s.timing <= TIMING_RST;
            s.pat_hi <= PAT_HI_RST;                                 // R8
            s.pat_lo <= PAT_LO_RST;
            s.st     <= ST_LISTEN;
        end
        else
            s <= n;
    end

    assign awready = !s.aw_held && !s.bvalid;
    assign wready  = !s.w_held && !s.bvalid;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign arready = !s.rvalid;
    assign rvalid  = s.rvalid;
    assign rdata   = s.rdata;
    assign rresp   = s.rresp;
    assign wake    = s.wake;
    assign decoded_bitstream_out = s.dec_data & s.ctrl[DEC_EN_BIT]; // R13
    assign recovered_bit_clock   = s.dec_clk & s.ctrl[DEC_EN_BIT];  // R13

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_corr_gate;
        s.st == ST_LISTEN && car_rise && s.ctrl[CORR_EN_BIT]
            |=> s.st == ST_PREAMBLE && !wake;
    endproperty
    a_corr_gate: assert property (p_corr_gate) // R1
        else $error("correlator enabled but no preamble search");
    property p_direct_wake;
        s.st == ST_LISTEN && car_rise && !s.ctrl[CORR_EN_BIT] |=> wake;
    endproperty
    a_direct_wake: assert property (p_direct_wake) // R19
        else $error("no wake on carrier with correlator off");
    property p_preamble_window;
        s.st == ST_PREAMBLE |-> s.chip_cnt < CARRIER_WAIT;
    endproperty
    a_preamble_window: assert property (p_preamble_window) // R2
        else $error("preamble wait exceeded sixteen bits");
    property p_preamble_min;
        s.st == ST_PREAMBLE ##1 s.st == ST_PATTERN
            |-> $past(s.pre_cnt) == PREAMBLE_MIN - 3'h1;
    endproperty
    a_preamble_min: assert property (p_preamble_min) // R3
        else $error("pattern search began without four preamble bits");
    property p_tick_range;
        s.tick_cnt <= eff_code && eff_code >= BP_MIN_CODE;
    endproperty
    a_tick_range: assert property (p_tick_range) // R4
        else $error("bit period counter outside selected code");
    property p_fail_count;
        fail && s.fcnt != 8'hFF |=> s.fcnt == $past(s.fcnt) + 8'h01
                                   && s.st == ST_LISTEN && !wake;
    endproperty
    a_fail_count: assert property (p_fail_count) // R15
        else $error("false wakeup not counted");
    property p_fail_saturate;
        fail && s.fcnt == 8'hFF |=> s.fcnt == 8'hFF;
    endproperty
    a_fail_saturate: assert property (p_fail_saturate) // R21
        else $error("false wakeup counter wrapped");
    property p_double_needs_bit;
        s.st == ST_PATTERN ##1 s.st == ST_DOUBLE |-> s.ctrl[DOUBLE_BIT];
    endproperty
    a_double_needs_bit: assert property (p_double_needs_bit) // R10
        else $error("second pattern awaited in single mode");
    property p_clear_wake;
        s.st == ST_WAKE && clear_cmd |=> !wake ##1 !wake;
    endproperty
    a_clear_wake: assert property (p_clear_wake) // R16
        else $error("clear wake command ignored");
    property p_data_stable;
        $rose(recovered_bit_clock) |-> $stable(decoded_bitstream_out);
    endproperty
    a_data_stable: assert property (p_data_stable) // R14
        else $error("decoded data moved at clock rise");
    property p_timeout_start;
        $rose(wake) |-> s.to_cnt == 14'h0000;
    endproperty
    a_timeout_start: assert property (p_timeout_start) // R18
        else $error("timeout count not fresh at wake rise");
    c_single_wake: cover property (s.st == ST_PATTERN ##1 $rose(wake));
    c_double_wake: cover property (s.st == ST_DOUBLE ##1 $rose(wake));
    c_false_wake:  cover property (fail);
    c_dec_clock:   cover property ($rose(recovered_bit_clock));
endmodule // wakeup_pattern_correlator
`default_nettype wire

/* File: tb/lf_tx_model.sv */
// transmitter model: carrier burst carrying on/off keyed chips
// assumes the bench calls send; chips go out one per bit period
`timescale 1ns/1ps
`default_nettype none
module lf_tx_model (
    input  wire logic aclk,           // bench clock
    output logic      carrier_detect, // carrier present
    output logic      demod_data      // keyed chip level
);
    initial
    begin
        carrier_detect = 1'b0;
        demod_data     = 1'b0;
    end

    // no carrier means no keyed level, so idle low is the real level
    task automatic send(input logic [63:0] chips, input int n, input int cyc);
        @(posedge aclk);
        carrier_detect <= 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            demod_data <= chips[i];
            repeat (cyc) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
        carrier_detect <= 1'b0;
        demod_data     <= 1'b0;
    endtask
endmodule // lf_tx_model
`default_nettype wire

/* File: tb/wakeup_pattern_correlator_test.sv */
// bench for the wakeup correlator: registers over axi4-lite, frames
// assumes lf_tx_model drives carrier and chips, fast rtc parameters
`timescale 1ns/1ps
`default_nettype none
module wakeup_pattern_correlator_test;
    import wakeup_corr_pkg::*;
    localparam int          CYC = 16; // aclk cycles per bit at code 3
    localparam logic [15:0] PAT = {PAT_HI_RST, PAT_LO_RST};
    localparam logic [3:0]  PRE = 4'hA;
    logic              aclk, aresetn, awvalid, awready, wvalid, wready;
    logic              bvalid, bready, arvalid, arready, rvalid, rready;
    logic              carrier_detect, demod_data, wake, dec_out, rec_clk;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic [15:0]       miss [1:3];
    int                num_errors, compares, exp_false;

    wakeup_pattern_correlator #(.RTC_DIV(4), .TO_STEP(3))
        wakeup_pattern_correlator_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .carrier_detect(carrier_detect), .demod_data(demod_data),
        .wake(wake), .decoded_bitstream_out(dec_out),
        .recovered_bit_clock(rec_clk));

    lf_tx_model lf_tx_model_inst (
        .aclk(aclk), .carrier_detect(carrier_detect),
        .demod_data(demod_data));

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid)
            @(posedge aclk);
        bready <= 1'b0;
        check(bresp, r);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        while (!rvalid)
            @(posedge aclk);
        rready <= 1'b0;
        check(rdata, {24'h000000, d});
        check(rresp, r);
    endtask

    // a failed search may run 36 bits past a preamble found late
    task automatic frame(input logic [63:0] chips, input int n,
                         input logic exp);
        lf_tx_model_inst.send(chips, n, CYC);
        repeat ((48 - n) * CYC) @(posedge aclk);
        check(wake, exp);
        if (exp)
        begin
            rd(OFS_CMD, 8'h09, RESP_OKAY);
            wr(OFS_CMD, 8'h01, RESP_OKAY);
        end
        else
            exp_false++;
        repeat (2) @(posedge aclk);
        check(wake, 1'b0);
        rd(OFS_FALSE, exp_false[7:0], RESP_OKAY);
    endtask

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr     = '0;
        araddr     = '0;
        wdata      = '0;
        wstrb      = 4'hF;
        num_errors = 0;
        compares   = 0;
        exp_false  = 0;
        miss[1]    = 16'h0002;
        miss[2]    = 16'h0006;
        miss[3]    = 16'h0016;
        aresetn    = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
        rd(OFS_TIMING, TIMING_RST, RESP_OKAY);
        rd(OFS_PAT_HI, 8'h96, RESP_OKAY);
        rd(OFS_PAT_LO, PAT_LO_RST, RESP_OKAY);
        rd(5'h18, 8'h00, RESP_SLVERR);
        wr(5'h1C, 8'hFF, RESP_SLVERR);
        wr(OFS_TIMING, 8'h03, RESP_OKAY);
        frame('0, 0, 1'b1);
        wr(OFS_CTRL, 8'h02, RESP_OKAY);
        frame({PRE, PAT}, 20, 1'b1);
        frame({PRE, ~PAT}, 20, 1'b0);
        frame('0, 0, 1'b0);
        frame({4'h8, PAT}, 20, 1'b0);
        for (int t = 1; t <= 3; t++)
            for (int k = 0; k <= 1; k++)
            begin
                wr(OFS_CTRL, 8'h02 | 8'((t - 1 + k) << TOL_LSB), RESP_OKAY);
                frame({PRE, PAT | miss[t]}, 20, k[0]);
            end
        wr(OFS_CTRL, 8'h06, RESP_OKAY);
        frame({PRE, PAT, PAT}, 36, 1'b1);
        frame({PRE, PAT}, 20, 1'b0);
        wr(OFS_CTRL, 8'h02, RESP_OKAY);
        wr(OFS_TIMING, 8'h00, RESP_OKAY);
        frame({PRE, PAT}, 20, 1'b1);
        wr(OFS_CTRL, 8'h0A, RESP_OKAY);
        fork
            frame({PRE, PAT, 4'h9}, 24, 1'b1);
            begin
                repeat (2) @(posedge rec_clk);
                check(dec_out, 1'b1);
                @(posedge rec_clk);
                check(dec_out, 1'b0);
            end
        join
        wr(OFS_CTRL, 8'h00, RESP_OKAY);
        wr(OFS_TIMING, 8'h23, RESP_OKAY);
        lf_tx_model_inst.send('0, 0, CYC);
        check(wake, 1'b1);
        repeat (20) @(posedge aclk);
        check(wake, 1'b0);
        final_report();
    end

    initial
    begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule // wakeup_pattern_correlator_test
`default_nettype wire
